// ==== inc/mic_pkg.sv ====
package mic_pkg;

   localparam int unsigned MIC_DATA_W = 32;
   localparam int unsigned MIC_FLAG_W = 4;
   localparam int unsigned MIC_OFF_W  = 5;

   // register byte offsets
   localparam logic [MIC_OFF_W-1:0] MIC_OFF_FLAGS1 = 5'h00;
   localparam logic [MIC_OFF_W-1:0] MIC_OFF_FLAGS2 = 5'h04;
   localparam logic [MIC_OFF_W-1:0] MIC_OFF_FLAGS3 = 5'h08;
   localparam logic [MIC_OFF_W-1:0] MIC_OFF_MASK1  = 5'h0c;
   localparam logic [MIC_OFF_W-1:0] MIC_OFF_MASK2  = 5'h10;
   localparam logic [MIC_OFF_W-1:0] MIC_OFF_MASK3  = 5'h14;
   localparam logic [MIC_OFF_W-1:0] MIC_OFF_CTRL   = 5'h18;

   // system_control_one fields
   localparam int unsigned MIC_CTRL_EN_BIT  = 0;
   localparam int unsigned MIC_CTRL_SEL_BIT = 1;

   // request_flags_second fields
   localparam int unsigned MIC_F2_COMPARE = 0;
   localparam int unsigned MIC_F2_BLINK   = 1;
   localparam int unsigned MIC_F2_HZ32_8  = 2;
   localparam int unsigned MIC_F2_ONE_HZ  = 3;

   // request_flags_third fields
   localparam int unsigned MIC_F3_CNT_COMP = 0;
   localparam int unsigned MIC_F3_CNT_ZERO = 1;
   localparam int unsigned MIC_F3_MSC      = 2;
   localparam int unsigned MIC_F3_VLD      = 3;

   localparam logic [MIC_FLAG_W-1:0] MIC_FLAGS_RST = 4'h0;
   localparam logic [MIC_FLAG_W-1:0] MIC_FLAGS_ALL = 4'hf;

   localparam logic [1:0] MIC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] MIC_RESP_SLVERR = 2'h2;

endpackage : mic_pkg

// ==== core/mic_collector.sv ====
// Notes on behaviour
// - twelve request sources, each with its own mask bit gating latching
// - external sources: port A bits 3..0 and the compare input
// - internal sources: prescaler taps, millisecond, counter events, supply detector
// - supply detector and compare requests share one common request line
// - interrupt asserted only while a flag is set and global enable is one
// - flag set only on a rising source edge while its mask is one
// - reset clears every mask bit and the global enable
// - reading a flag register returns it, then clears that register
// - writing one clears a single flag; writing zero leaves it
// - no hardware priority among sources; software picks the order
// - requests during service stay latched and raise a new interrupt
// - an edge arriving while masked is discarded
// - latching depends on masks only, not on the global enable
// - entering halt forces the global enable to one
// - millisecond request picks tenth or one second; tenth after reset
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
module mic_collector
   import mic_pkg::*;
#(
   parameter int unsigned ADDR_W = 5
)
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output      logic              awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output      logic              wready,
   output      logic [1:0]        bresp,
   output      logic              bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output      logic              arready,
   output      logic [31:0]       rdata,
   output      logic [1:0]        rresp,
   output      logic              rvalid,
   input  wire logic              rready,
   input  wire logic [3:0]        port_a_inputs,
   input  wire logic              compare_input,
   input  wire logic              prescaler_one_hz_tap,
   input  wire logic              prescaler_blink_tap,
   input  wire logic              prescaler_hz32_8_tap,
   input  wire logic              msc_tenth_sec_event,
   input  wire logic              msc_one_sec_event,
   input  wire logic              counter_zero_event,
   input  wire logic              counter_compare_event,
   input  wire logic              supply_level_detector,
   input  wire logic              halt_mode,
   output      logic              global_irq_enable,
   output      logic              irq
);

   if (ADDR_W < MIC_OFF_W)
   begin : g_addr_check
      $error("mic_collector: ADDR_W too small for the register map");
   end

   ////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic [3:0]        pa_meta;
      logic [3:0]        pa_sync;
      logic [3:0]        pa_prev;
      logic              cmp_meta;
      logic              cmp_sync;
      logic [3:0]        prev2;
      logic [3:0]        prev3;
      logic              halt_prev;
      logic [3:0]        flags1;
      logic [3:0]        flags2;
      logic [3:0]        flags3;
      logic [3:0]        mask1;
      logic [3:0]        mask2;
      logic [3:0]        mask3;
      logic              gie;
      logic              msc_sel;
      logic              aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_held;
      logic [31:0]       w_data;
      logic [3:0]        w_strb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } mic_state_t;

   mic_state_t st;
   mic_state_t next_st;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic mic_is(input logic [ADDR_W-1:0]    a,
                                   input logic [MIC_OFF_W-1:0] off);
      mic_is = (a == ADDR_W'(off));
   endfunction : mic_is

   function automatic logic mic_mapped(input logic [ADDR_W-1:0] a);
      mic_mapped = mic_is(a, MIC_OFF_FLAGS1) || mic_is(a, MIC_OFF_FLAGS2) ||
                   mic_is(a, MIC_OFF_FLAGS3) || mic_is(a, MIC_OFF_MASK1)  ||
                   mic_is(a, MIC_OFF_MASK2)  || mic_is(a, MIC_OFF_MASK3)  ||
                   mic_is(a, MIC_OFF_CTRL);
   endfunction : mic_mapped

   // set wins over clear
   function automatic logic [3:0] mic_update(input logic [3:0] flags,
                                             input logic [3:0] clr,
                                             input logic [3:0] set);
      mic_update = (flags & ~clr) | set;
   endfunction : mic_update

   function automatic logic [3:0] mic_clr(input logic              fire,
                                          input logic [ADDR_W-1:0] a,
                                          input logic [MIC_OFF_W-1:0] off,
                                          input logic [3:0]        bits);
      mic_clr = (fire && mic_is(a, off)) ? bits : MIC_FLAGS_RST;
   endfunction : mic_clr

   ////////////////////////////////////////////////////////////////////////
   // request sources and edge detection

   logic [3:0] raw2;
   logic [3:0] raw3;
   logic       msc_src;
   logic       shared_line;
   logic [3:0] set1;
   logic [3:0] set2;
   logic [3:0] set3;
   logic       wr_fire;
   logic       rd_fire;
   logic [3:0] wbits;
   logic [3:0] rclr1;
   logic [3:0] rclr2;
   logic [3:0] rclr3;
   logic [3:0] wclr1;
   logic [3:0] wclr2;
   logic [3:0] wclr3;
   logic       halt_rise;

   assign msc_src = st.msc_sel ? msc_one_sec_event
                               : msc_tenth_sec_event;

   always_comb
   begin
      raw2                 = '0;
      raw2[MIC_F2_COMPARE] = st.cmp_sync;
      raw2[MIC_F2_BLINK]   = prescaler_blink_tap;
      raw2[MIC_F2_HZ32_8]  = prescaler_hz32_8_tap;
      raw2[MIC_F2_ONE_HZ]  = prescaler_one_hz_tap;
      raw3                 = '0;
      raw3[MIC_F3_CNT_COMP] = counter_compare_event;
      raw3[MIC_F3_CNT_ZERO] = counter_zero_event;
      raw3[MIC_F3_MSC]      = msc_src;
      raw3[MIC_F3_VLD]      = supply_level_detector;
   end

   // rising edge and mask only; global enable plays no part
   assign set1 = st.pa_sync & ~st.pa_prev & st.mask1;
   assign set2 = raw2 & ~st.prev2 & st.mask2;
   assign set3 = raw3 & ~st.prev3 & st.mask3;

   ////////////////////////////////////////////////////////////////////////
   // bus decode

   assign awready = !st.aw_held;
   assign wready  = !st.w_held;
   assign arready = !st.rvalid;
   assign wr_fire = st.aw_held && st.w_held && !st.bvalid;
   assign rd_fire = arvalid && arready;
   assign wbits   = st.w_strb[0] ? st.w_data[3:0] : MIC_FLAGS_RST;

   assign rclr1 = mic_clr(rd_fire, araddr, MIC_OFF_FLAGS1, MIC_FLAGS_ALL);
   assign rclr2 = mic_clr(rd_fire, araddr, MIC_OFF_FLAGS2, MIC_FLAGS_ALL);
   assign rclr3 = mic_clr(rd_fire, araddr, MIC_OFF_FLAGS3, MIC_FLAGS_ALL);
   assign wclr1 = mic_clr(wr_fire, st.aw_addr, MIC_OFF_FLAGS1, wbits);
   assign wclr2 = mic_clr(wr_fire, st.aw_addr, MIC_OFF_FLAGS2, wbits);
   assign wclr3 = mic_clr(wr_fire, st.aw_addr, MIC_OFF_FLAGS3, wbits);

   assign halt_rise = halt_mode && !st.halt_prev;

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      next_st = st;

      // two-stage synchronisers for pins
      next_st.pa_meta  = port_a_inputs;
      next_st.pa_sync  = st.pa_meta;
      next_st.pa_prev  = st.pa_sync;
      next_st.cmp_meta = compare_input;
      next_st.cmp_sync = st.cmp_meta;
      next_st.prev2    = raw2;
      next_st.prev3    = raw3;
      next_st.halt_prev = halt_mode;

      // flags stay latched until software clears them
      next_st.flags1 = mic_update(st.flags1, rclr1 | wclr1, set1);
      next_st.flags2 = mic_update(st.flags2, rclr2 | wclr2, set2);
      next_st.flags3 = mic_update(st.flags3, rclr3 | wclr3, set3);

      // write channel
      if (awvalid && awready)
      begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = awaddr;
      end
      if (wvalid && wready)
      begin
         next_st.w_held = 1'b1;
         next_st.w_data = wdata;
         next_st.w_strb = wstrb;
      end
      if (wr_fire)
      begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = mic_mapped(st.aw_addr) ? MIC_RESP_OKAY
                                                  : MIC_RESP_SLVERR;
         if (st.w_strb[0])
         begin
            if (mic_is(st.aw_addr, MIC_OFF_MASK1))
            begin
               next_st.mask1 = st.w_data[3:0];
            end
            if (mic_is(st.aw_addr, MIC_OFF_MASK2))
            begin
               next_st.mask2 = st.w_data[3:0];
            end
            if (mic_is(st.aw_addr, MIC_OFF_MASK3))
            begin
               next_st.mask3 = st.w_data[3:0];
            end
            if (mic_is(st.aw_addr, MIC_OFF_CTRL))
            begin
               next_st.gie     = st.w_data[MIC_CTRL_EN_BIT];
               next_st.msc_sel = st.w_data[MIC_CTRL_SEL_BIT];
            end
         end
      end
      else if (st.bvalid && bready)
      begin
         next_st.bvalid = 1'b0;
      end

      // halt entry overrides a software write in the same cycle
      if (halt_rise)
      begin
         next_st.gie = 1'b1;
      end

      // read channel
      if (rd_fire)
      begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = mic_mapped(araddr) ? MIC_RESP_OKAY
                                             : MIC_RESP_SLVERR;
         next_st.rdata  = '0;
         if (mic_is(araddr, MIC_OFF_FLAGS1))
         begin
            next_st.rdata[3:0] = st.flags1;
         end
         if (mic_is(araddr, MIC_OFF_FLAGS2))
         begin
            next_st.rdata[3:0] = st.flags2;
         end
         if (mic_is(araddr, MIC_OFF_FLAGS3))
         begin
            next_st.rdata[3:0] = st.flags3;
         end
         if (mic_is(araddr, MIC_OFF_MASK1))
         begin
            next_st.rdata[3:0] = st.mask1;
         end
         if (mic_is(araddr, MIC_OFF_MASK2))
         begin
            next_st.rdata[3:0] = st.mask2;
         end
         if (mic_is(araddr, MIC_OFF_MASK3))
         begin
            next_st.rdata[3:0] = st.mask3;
         end
         if (mic_is(araddr, MIC_OFF_CTRL))
         begin
            next_st.rdata[MIC_CTRL_EN_BIT]  = st.gie;
            next_st.rdata[MIC_CTRL_SEL_BIT] = st.msc_sel;
         end
      end
      else if (st.rvalid && rready)
      begin
         next_st.rvalid = 1'b0;
      end
   end

   // all reset values are zero: masks, enable and select cleared
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   // compare and supply detector flags feed one common request line
   assign shared_line = st.flags2[MIC_F2_COMPARE] ||
                        st.flags3[MIC_F3_VLD];

   // plain OR of all flags, no priority
   assign irq = st.gie && (shared_line || (|st.flags1) ||
                (|st.flags2) || (|st.flags3));

   assign global_irq_enable = st.gie;
   assign bvalid = st.bvalid;
   assign bresp  = st.bresp;
   assign rvalid = st.rvalid;
   assign rdata  = st.rdata;
   assign rresp  = st.rresp;

   ////////////////////////////////////////////////////////////////////////
   // checks

   irq_gate_a : assert property (@(posedge aclk) disable iff (!aresetn)
      irq |-> st.gie && (|{st.flags1, st.flags2, st.flags3}))
      else $error("interrupt without enable or flag");

   masked_drop_a : assert property (@(posedge aclk)
      disable iff (!aresetn)
      (!st.mask1[0] && !st.flags1[0]) |=> !st.flags1[0])
      else $error("masked edge was latched");

   edge_latch_a : assert property (@(posedge aclk)
      disable iff (!aresetn)
      (st.mask1[0] && st.pa_sync[0] && !st.pa_prev[0]) |=> st.flags1[0])
      else $error("unmasked edge not latched");

   read_clear_a : assert property (@(posedge aclk)
      disable iff (!aresetn)
      (rd_fire && mic_is(araddr, MIC_OFF_FLAGS3) && set3 == 4'h0)
      |=> st.flags3 == 4'h0 && st.rdata[3:0] == $past(st.flags3))
      else $error("read did not return and clear flags");

   halt_enable_a : assert property (@(posedge aclk)
      disable iff (!aresetn)
      halt_rise |=> st.gie ##0 global_irq_enable)
      else $error("halt entry did not set enable");

   reset_clear_a : assert property (@(posedge aclk)
      !aresetn |=> st.mask1 == 4'h0 && st.mask2 == 4'h0 &&
      st.mask3 == 4'h0 && !st.gie && !st.msc_sel && !irq)
      else $error("reset left masks or enable set");

   set_wins_a : assert property (@(posedge aclk)
      disable iff (!aresetn)
      (|set3) |=> (st.flags3 & $past(set3)) == $past(set3))
      else $error("new request lost on clear");

   w1c_keep_a : assert property (@(posedge aclk)
      disable iff (!aresetn)
      (wr_fire && mic_is(st.aw_addr, MIC_OFF_FLAGS2) && set2 == 4'h0 &&
       !rd_fire)
      |=> st.flags2 == ($past(st.flags2) & ~$past(wbits)))
      else $error("write-one clear wrong");

   read_answer_a : assert property (@(posedge aclk)
      disable iff (!aresetn)
      rd_fire |=> rvalid)
      else $error("read answer missing");

   read_hold_a : assert property (@(posedge aclk)
      disable iff (!aresetn)
      (rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer dropped before taken");

endmodule : mic_collector

// ==== testbench/mic_sources.sv ====
module mic_sources
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [12:0] fire,
   input  wire logic        halt_req,
   output      logic [3:0]  port_a_inputs,
   output      logic        compare_input,
   output      logic        prescaler_blink_tap,
   output      logic        prescaler_hz32_8_tap,
   output      logic        prescaler_one_hz_tap,
   output      logic        counter_compare_event,
   output      logic        counter_zero_event,
   output      logic        msc_tenth_sec_event,
   output      logic        supply_level_detector,
   output      logic        msc_one_sec_event,
   output      logic        halt_mode
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [12:0] lvl;

   // source levels follow the bench's requests one clock later
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         lvl       <= 13'h0000;
         halt_mode <= 1'b0;
      end
      else
      begin
         lvl       <= fire;
         halt_mode <= halt_req;
      end
   end

   assign {msc_one_sec_event, supply_level_detector, msc_tenth_sec_event,
           counter_zero_event, counter_compare_event, prescaler_one_hz_tap,
           prescaler_hz32_8_tap, prescaler_blink_tap, compare_input,
           port_a_inputs} = lvl;
endmodule : mic_sources

// ==== testbench/tb_maskable_irq_collector.sv ====
module tb_maskable_irq_collector
   import mic_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, halt_req;
   logic [4:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, lfsr_q;
   logic [3:0]  wstrb, port_a_inputs;
   logic [1:0]  bresp, rresp;
   logic [12:0] fire;
   logic compare_input, prescaler_one_hz_tap, prescaler_blink_tap;
   logic prescaler_hz32_8_tap, msc_tenth_sec_event, msc_one_sec_event;
   logic counter_zero_event, counter_compare_event, supply_level_detector;
   logic halt_mode, global_irq_enable, irq;
   logic [33:0] rq[$];
   logic [1:0]  bq[$];
   int n_mismatch = 0;
   int check_count = 0;

   mic_collector #(.ADDR_W(5)) u_dut (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .port_a_inputs(port_a_inputs),
      .compare_input(compare_input),
      .prescaler_one_hz_tap(prescaler_one_hz_tap),
      .prescaler_blink_tap(prescaler_blink_tap),
      .prescaler_hz32_8_tap(prescaler_hz32_8_tap),
      .msc_tenth_sec_event(msc_tenth_sec_event),
      .msc_one_sec_event(msc_one_sec_event),
      .counter_zero_event(counter_zero_event),
      .counter_compare_event(counter_compare_event),
      .supply_level_detector(supply_level_detector), .halt_mode(halt_mode),
      .global_irq_enable(global_irq_enable), .irq(irq));

   mic_sources u_src (.aclk(aclk), .aresetn(aresetn), .fire(fire),
      .halt_req(halt_req), .port_a_inputs(port_a_inputs),
      .compare_input(compare_input), .prescaler_blink_tap(prescaler_blink_tap),
      .prescaler_hz32_8_tap(prescaler_hz32_8_tap),
      .prescaler_one_hz_tap(prescaler_one_hz_tap),
      .counter_compare_event(counter_compare_event),
      .counter_zero_event(counter_zero_event),
      .msc_tenth_sec_event(msc_tenth_sec_event),
      .supply_level_detector(supply_level_detector),
      .msc_one_sec_event(msc_one_sec_event), .halt_mode(halt_mode));

   always #10 aclk = ~aclk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic complete_run();
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   // enable and irq levels, sampled away from the clock edge
   task automatic chk_out(input logic e_en, input logic e_irq);
      @(negedge aclk);
      chk({32'h0, global_irq_enable, irq}, {32'h0, e_en, e_irq});
   endtask : chk_out

   task automatic wr(input logic [4:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      int  n;
      logic ta, tw, tb;
      n  = 0;
      tb = 1'b0;
      bq.push_back(r);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!tb && n < 50)
      begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid & bready & !awvalid & !wvalid;
         n++;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
      end
      if (!tb) n_mismatch++;
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      int  n;
      logic ta, tr;
      n  = 0;
      tr = 1'b0;
      rq.push_back({r, d});
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!tr && n < 50)
      begin
         @(negedge aclk);
         ta = arvalid & arready;
         tr = rvalid & rready & !arvalid;
         n++;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         if (tr) rready <= 1'b0;
      end
      if (!tr) n_mismatch++;
   endtask : rd

   task automatic pulse(input logic [12:0] v);
      @(posedge aclk);
      fire <= v;
      repeat (4) @(posedge aclk);
      fire <= 13'h0000;
      repeat (6) @(posedge aclk);
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge aclk)
   begin
      if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
      if (bvalid && bready) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
   end

   initial
   begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      complete_run();
   end

   initial
   begin
      aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0;
      arvalid = 0; rready = 0; awaddr = 0; araddr = 0; wdata = 0;
      wstrb = 0; fire = 0; halt_req = 0; lfsr_q = 32'hed7c;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      chk_out(1'b0, 1'b0);
      for (int i = 0; i < 7; i++)
         rd(5'(4 * i), 32'h0, MIC_RESP_OKAY);
      pulse(13'h0fff);
      for (int i = 0; i < 3; i++)
         rd(5'(4 * i), 32'h0, MIC_RESP_OKAY);
      for (int i = 0; i < 3; i++)
         wr(5'(12 + 4 * i), 32'hf, MIC_RESP_OKAY);
      pulse(13'h0fff);
      chk_out(1'b0, 1'b0);
      wr(MIC_OFF_CTRL, 32'h1, MIC_RESP_OKAY);
      chk_out(1'b1, 1'b1);
      rd(MIC_OFF_FLAGS1, 32'hf, MIC_RESP_OKAY);
      rd(MIC_OFF_FLAGS1, 32'h0, MIC_RESP_OKAY);
      wr(MIC_OFF_FLAGS2, 32'h5, MIC_RESP_OKAY);
      rd(MIC_OFF_FLAGS2, 32'ha, MIC_RESP_OKAY);
      chk_out(1'b1, 1'b1);
      rd(MIC_OFF_FLAGS3, 32'hf, MIC_RESP_OKAY);
      chk_out(1'b1, 1'b0);
      pulse(13'h0800);
      chk_out(1'b1, 1'b1);
      rd(MIC_OFF_FLAGS3, 32'h8, MIC_RESP_OKAY);
      pulse(13'h0010);
      chk_out(1'b1, 1'b1);
      rd(MIC_OFF_FLAGS2, 32'h1, MIC_RESP_OKAY);
      wr(MIC_OFF_CTRL, 32'h3, MIC_RESP_OKAY);
      pulse(13'h0400);
      rd(MIC_OFF_FLAGS3, 32'h0, MIC_RESP_OKAY);
      pulse(13'h1000);
      rd(MIC_OFF_FLAGS3, 32'h4, MIC_RESP_OKAY);
      wr(MIC_OFF_CTRL, 32'h1, MIC_RESP_OKAY);
      pulse(13'h0400);
      rd(MIC_OFF_FLAGS3, 32'h4, MIC_RESP_OKAY);
      // new counter edge lands on the same edge as the clearing read
      fork
         pulse(13'h0100);
         begin
            @(posedge aclk);
            rd(MIC_OFF_FLAGS3, 32'h0, MIC_RESP_OKAY);
         end
      join
      rd(MIC_OFF_FLAGS3, 32'h1, MIC_RESP_OKAY);
      rd(5'h1c, 32'h0, MIC_RESP_SLVERR);
      wr(5'h1c, 32'hf, MIC_RESP_SLVERR);
      for (int k = 0; k < 6; k++)
      begin
         lfsr_q = lfsr_next(lfsr_q);
         for (int i = 0; i < 3; i++)
            wr(5'(12 + 4 * i), {28'h0, lfsr_q[4*i +: 4]}, MIC_RESP_OKAY);
         pulse({1'b0, lfsr_q[27:16]});
         for (int i = 0; i < 3; i++)
            rd(5'(4 * i), {28'h0, lfsr_q[4*i +: 4] & lfsr_q[16+4*i +: 4]},
               MIC_RESP_OKAY);
      end
      wr(MIC_OFF_CTRL, 32'h0, MIC_RESP_OKAY);
      chk_out(1'b0, 1'b0);
      @(posedge aclk);
      halt_req <= 1'b1;
      repeat (3) @(posedge aclk);
      chk_out(1'b1, 1'b0);
      @(posedge aclk);
      halt_req <= 1'b0;
      repeat (2) @(posedge aclk);
      // mid-run reset with mask1, enable and select set
      wr(MIC_OFF_MASK1, 32'hf, MIC_RESP_OKAY);
      wr(MIC_OFF_CTRL, 32'h3, MIC_RESP_OKAY);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      chk_out(1'b0, 1'b0);
      for (int i = 3; i < 7; i++)
         rd(5'(4 * i), 32'h0, MIC_RESP_OKAY);
      complete_run();
   end
endmodule : tb_maskable_irq_collector
